// [hw/wti_watch_timer.v]
`timescale 1ns/1ps
`include "wti_regs.vh"
module wti_watch_timer (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire prescaler_run_bit,
  input wire counter_run_bit,
  input wire watch_period_sel_lo,
  input wire watch_period_sel_hi,
  input wire tick_period_sel_0,
  input wire tick_period_sel_1,
  input wire tick_period_sel_2,
  input wire source_clock_sel,
  input wire subsys_clk_in,
  output reg watch_overflow_irq,
  output reg interval_tick_irq,
  output reg [4:0] watch_count,
  output reg [10:0] prescaler_count
);
  localparam ST_STOP = 2'h0;
  localparam ST_TICK = 2'h1;
  localparam ST_WATCH = 2'h2;

  wire sub_level;
  reg sub_prev;
  reg [6:0] div128;
  reg src_tick;
  reg next_src_tick;
  reg [1:0] state;
  reg [1:0] next_state;
  wire [1:0] wsel;
  wire [2:0] tsel;
  wire [10:0] next_pre;
  wire [10:0] pre_rise;
  wire [4:0] next_cnt;
  reg pre_edge;
  reg cnt_edge;
  reg watch_hit;
  reg pre_run;
  reg cnt_run;

  // Subsystem clock is slow and foreign, so it is sampled rather than used as a clock
  wti_sync3 u_sub_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .din(subsys_clk_in),
    .dout(sub_level)
  );

  assign wsel = {watch_period_sel_hi, watch_period_sel_lo};
  assign tsel = {tick_period_sel_2, tick_period_sel_1, tick_period_sel_0};
  assign next_pre = prescaler_count + 11'h001;
  // Bits that go from zero to one on the next prescaler step
  assign pre_rise = next_pre & ~prescaler_count;
  assign next_cnt = watch_count + 5'h01;

  always @* begin
    next_state = ST_STOP;
    case ({prescaler_run_bit, counter_run_bit})
      2'b11: begin
        next_state = ST_WATCH;
      end
      2'b10: begin
        next_state = ST_TICK;
      end
      default: begin
        next_state = ST_STOP;
      end
    endcase
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_STOP;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Source clock enable: one mclk pulse per watch_source_freq period
  always @* begin
    next_src_tick = 1'b0;
    if (source_clock_sel) begin
      next_src_tick = sub_level & ~sub_prev;
    end else begin
      next_src_tick = (div128 == `WTI_DIV128_LAST);
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sub_prev <= 1'b0;
      div128 <= 7'h00;
      src_tick <= 1'b0;
    end else if (ce) begin
      sub_prev <= sub_level;
      div128 <= div128 + 7'h01;
      src_tick <= next_src_tick;
    end
  end

  // Which stages advance on this source tick
  always @* begin
    pre_run = 1'b0;
    cnt_run = 1'b0;
    case (state)
      ST_TICK: begin
        pre_run = src_tick;
      end
      ST_WATCH: begin
        pre_run = src_tick;
        cnt_run = src_tick;
      end
      default: begin
        pre_run = 1'b0;
      end
    endcase
  end

  // Rising edge of the chosen prescaler bit when it increments
  always @* begin
    pre_edge = 1'b0;
    case (tsel)
      3'h0: begin
        pre_edge = pre_rise[`WTI_TICK_BIT_2P4];
      end
      3'h1: begin
        pre_edge = pre_rise[`WTI_TICK_BIT_2P5];
      end
      3'h2: begin
        pre_edge = pre_rise[`WTI_TICK_BIT_2P6];
      end
      3'h3: begin
        pre_edge = pre_rise[`WTI_TICK_BIT_2P7];
      end
      3'h4: begin
        pre_edge = pre_rise[`WTI_TICK_BIT_2P8];
      end
      3'h5: begin
        pre_edge = pre_rise[`WTI_TICK_BIT_2P9];
      end
      3'h6: begin
        pre_edge = pre_rise[`WTI_TICK_BIT_2P10];
      end
      default: begin
        pre_edge = pre_rise[`WTI_TICK_BIT_2P11];
      end
    endcase
  end

  // Long watch periods come from the 5-bit counter, short ones straight from the prescaler
  always @* begin
    cnt_edge = pre_rise[`WTI_PRE_CARRY_BIT];
    watch_hit = 1'b0;
    case (wsel)
      `WTI_WSEL_2P14: begin
        watch_hit = cnt_edge & (watch_count == `WTI_CNT_LAST);
      end
      `WTI_WSEL_2P13: begin
        watch_hit = cnt_edge & (watch_count[3:0] == `WTI_CNT_LO_LAST);
      end
      `WTI_WSEL_2P5: begin
        watch_hit = pre_rise[`WTI_TICK_BIT_2P5];
      end
      `WTI_WSEL_2P4: begin
        watch_hit = pre_rise[`WTI_TICK_BIT_2P4];
      end
      default: begin
        watch_hit = 1'b0;
      end
    endcase
  end

  // Prescaler keeps its value when stopped; a restart resumes its phase
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prescaler_count <= `WTI_PRE_RESET;
    end else if (ce) begin
      if (pre_run) begin
        prescaler_count <= next_pre;
      end
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      watch_count <= `WTI_CNT_RESET;
    end else if (ce) begin
      case (state)
        ST_STOP: begin
          watch_count <= `WTI_CNT_RESET;
        end
        ST_TICK: begin
          // Only the counter is zeroed, so the first long overflow may come early
          watch_count <= `WTI_CNT_RESET;
        end
        ST_WATCH: begin
          if (cnt_run && cnt_edge) begin
            watch_count <= next_cnt;
          end
        end
        default: begin
          watch_count <= `WTI_CNT_RESET;
        end
      endcase
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      watch_overflow_irq <= 1'b0;
      interval_tick_irq <= 1'b0;
    end else if (ce) begin
      interval_tick_irq <= pre_run & pre_edge;
      watch_overflow_irq <= cnt_run & watch_hit;
    end
  end
endmodule // wti_watch_timer

// [hw/wti_regs.vh]
`ifndef WTI_REGS_VH
`define WTI_REGS_VH
// Prescaler, watch counter and clock divider widths
`define WTI_PRE_W 11
`define WTI_CNT_W 5
`define WTI_DIV128_W 7
// Watch interval codes
`define WTI_WSEL_2P14 2'h0
`define WTI_WSEL_2P13 2'h1
`define WTI_WSEL_2P5 2'h2
`define WTI_WSEL_2P4 2'h3
// Prescaler bit whose carry clocks the 5-bit counter (2^9 stage)
`define WTI_PRE_CARRY_BIT 8
`define WTI_PRE_RESET 11'h000
`define WTI_CNT_RESET 5'h00
// Last state of the peripheral clock divider before it wraps
`define WTI_DIV128_LAST 7'h7f
// Prescaler bits whose rising edge marks each interval tick period
`define WTI_TICK_BIT_2P4 3
`define WTI_TICK_BIT_2P5 4
`define WTI_TICK_BIT_2P6 5
`define WTI_TICK_BIT_2P7 6
`define WTI_TICK_BIT_2P8 7
`define WTI_TICK_BIT_2P9 8
`define WTI_TICK_BIT_2P10 9
`define WTI_TICK_BIT_2P11 10
// Watch counter values that end a long watch period
`define WTI_CNT_LAST 5'h1f
`define WTI_CNT_LO_LAST 4'hf
`endif

// [hw/wti_sync3.v]
`timescale 1ns/1ps
// Three-stage synchroniser; a change is taken once stages two and three agree
module wti_sync3 (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule // wti_sync3

// [verif/wti_chk.sv]
`timescale 1ns/1ps
module wti_chk (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire prescaler_run_bit,
  input wire counter_run_bit,
  input wire watch_overflow_irq,
  input wire interval_tick_irq,
  input wire [4:0] watch_count,
  input wire [10:0] prescaler_count
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_reset_clear:
    assert property ($rose(reset_n) |-> {watch_count, prescaler_count} == 16'h0000)
    else $error("counts not clear");
  a_wcount_step:
    assert property (watch_count != $past(watch_count) && watch_count != 5'h00
      |-> watch_count == $past(watch_count) + 5'h01) else $error("watch count jump");
  a_pre_step:
    assert property (prescaler_count != $past(prescaler_count) && prescaler_count != 11'h000
      |-> prescaler_count == $past(prescaler_count) + 11'h001) else $error("prescaler jump");
  a_wcount_clear:
    assert property ((ce && !counter_run_bit) [*3] |=> watch_count == 5'h00)
    else $error("watch count not cleared");
  a_pre_hold:
    assert property ((!prescaler_run_bit) [*3] |=> $stable(prescaler_count))
    else $error("prescaler moves");
  a_tick_stop:
    assert property ((!prescaler_run_bit) [*3] |=> !interval_tick_irq && !watch_overflow_irq)
    else $error("event while stopped");
  a_wirq_pulse:
    assert property (watch_overflow_irq |=> !watch_overflow_irq) else $error("watch pulse");
  a_tirq_pulse:
    assert property (interval_tick_irq |=> !interval_tick_irq) else $error("tick pulse");
endmodule // wti_chk
bind wti_watch_timer wti_chk chk_u (.*);

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  reg mclk = 0, reset_n = 0, sclk = 0, pr = 0, cr = 0, ss = 1, ce = 1;
  reg [1:0] ws = 0;
  reg [2:0] ts = 0;
  reg [10:0] p;
  wire wi, ti;
  wire [4:0] wc;
  wire [10:0] pc;
  integer failures = 0, samples_checked = 0, cyc = 0, i;
  wti_watch_timer dut_u (.mclk(mclk), .reset_n(reset_n), .ce(ce), .prescaler_run_bit(pr),
    .counter_run_bit(cr), .watch_period_sel_lo(ws[0]), .watch_period_sel_hi(ws[1]),
    .tick_period_sel_0(ts[0]), .tick_period_sel_1(ts[1]), .tick_period_sel_2(ts[2]),
    .source_clock_sel(ss), .subsys_clk_in(sclk), .watch_overflow_irq(wi),
    .interval_tick_irq(ti), .watch_count(wc), .prescaler_count(pc));
  initial forever #2 mclk = ~mclk;
  // Subsystem clock is 8 mclk periods, every edge on an mclk falling edge
  initial forever #16 sclk = ~sclk;
  task chk(input string n, input [31:0] e, g);
    samples_checked = samples_checked + 1;
    if (e !== g) begin
      failures = failures + 1;
      $display("[FAIL] %s exp %0d got %0d", n, e, g);
    end
  endtask
  // Measures cycles between two pulses; the first pulse is only a reference
  task gap(input w, input [31:0] e);
    integer n;
    n = 1;
    while ((w ? wi : ti) !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    while ((w ? wi : ti) !== 1'b1) begin
      @(negedge mclk);
      n = n + 1;
    end
    chk(w ? "watch gap" : "tick gap", e, n);
  endtask
  task t_ticks;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge mclk) ts <= i[2:0];
      repeat (16) @(negedge mclk);
      gap(0, 8 << (i + 4));
    end
  endtask
  task t_watch;
    for (i = 2; i < 4; i = i + 1) begin
      @(posedge mclk) ws <= i[1:0];
      repeat (16) @(negedge mclk);
      gap(1, 8 << (7 - i));
    end
  endtask
  task t_div;
    @(posedge mclk) begin
      ss <= 0;
      ts <= 0;
    end
    repeat (300) @(negedge mclk);
    gap(0, 2048);
    @(posedge mclk) ce <= 0;
    @(negedge mclk);
    p = pc;
    repeat (300) @(negedge mclk);
    chk("ce freeze", p, pc);
    @(posedge mclk) ce <= 1;
  endtask
  task t_stop;
    @(posedge mclk) cr <= 0;
    repeat (4) @(negedge mclk);
    p = pc;
    chk("wcount", 0, wc);
    repeat (300) @(negedge mclk);
    chk("pre runs", 1, pc != p);
    @(posedge mclk) pr <= 0;
    repeat (4) @(negedge mclk);
    p = pc;
    repeat (300) @(negedge mclk);
    chk("pre stop", p, pc);
    chk("wcount stop", 0, wc);
  endtask
  task t_reset;
    @(posedge mclk) begin
      pr <= 1;
      cr <= 1;
    end
    repeat (300) @(negedge mclk);
    @(posedge mclk) reset_n <= 0;
    @(negedge mclk);
    chk("reset mid", 0, {wi, ti, wc, pc});
    @(posedge mclk) reset_n <= 1;
    @(negedge mclk);
    chk("reset out", 0, {wi, ti, wc, pc});
  endtask
  task end_of_test;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1;
    @(negedge mclk);
    chk("reset", 0, {wi, ti, wc, pc});
    @(posedge mclk) begin
      pr <= 1;
      cr <= 1;
    end
    t_ticks;
    t_watch;
    t_div;
    t_stop;
    t_reset;
    end_of_test;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
endmodule // tb_top
